// >>> src/dcp_config.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps

// What this block does
// RQ1: Debug-select one frees the debug pins as GPIO, zero reserves them.
// RQ2: Extension bit enables the extra instructions and indexed addressing.
// RQ3: Unused bits of both bytes always read back as zero.
// RQ4: Single-supply bit at one allows low-voltage programming entry.
// RQ5: The single-supply bit changes only by a write in high-voltage programming mode or by an erase.
// RQ6: Stack-fault bit at one turns stack full or underflow into a reset.
// RQ7: Unprogrammed, bits 7, 2 and 0 read one and the extension bit zero.
// RQ8: Each protect bit guards one block: one is open, zero is protected.
// RQ9: Protect bits 3 and 2 read on every part but are inert on small ones.
// RQ10: Protect bits only clear by writes, start at one, and need an erase.
module dcp_config #(
    parameter bit SMALL_MEM = 1'b0
) (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_NRST,
    input  wire logic [7:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR_STB,
    input  wire logic       I_RD_STB,
    output logic      [7:0] O_RDATA,
    input  wire logic       I_HV_PROG_MODE,
    input  wire logic       I_ERASE,
    input  wire logic       I_STACK_FULL,
    input  wire logic       I_STACK_UNDERFLOW,
    output logic            O_DEBUG_DATA_PIN_GPIO,
    output logic            O_EXT_INSTR_ENABLE,
    output logic            O_INDEXED_ADDR_ENABLE,
    output logic            O_SINGLE_SUPPLY_PROG_ENABLE,
    output logic            O_STACK_FAULT_RESET,
    output logic      [3:0] O_BLOCK_PROTECT
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    // Assert at once, release after two clean edges
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------------
    dcp_pkg::dcp_state_s st_r;
    dcp_pkg::dcp_state_s st_nxt;
    logic [7:0]          cfg_wr;
    logic                cfg_hit;
    logic                cp_hit;

    // Address decode shared by the write and read paths
    assign cfg_hit = (I_ADDR == dcp_pkg::CFG_ADDR);
    assign cp_hit  = (I_ADDR == dcp_pkg::CP_ADDR);

    // Next state: erase beats a write, reads see the value before any write
    always_comb begin
        st_nxt       = st_r;
        cfg_wr       = dcp_pkg::dcp_clean(I_WDATA, dcp_pkg::CFG_IMPL_MASK);
        st_nxt.rdata = 8'h00;
        // Fault request is one cycle per cycle of fault input
        st_nxt.stk_rst = (I_STACK_FULL | I_STACK_UNDERFLOW)
                       & st_r.cfg[dcp_pkg::STK_RST_BIT];             // RQ6
        if (!I_HV_PROG_MODE) begin
            // Low-voltage writes must not be able to lock out low-voltage entry
            cfg_wr[dcp_pkg::SSP_BIT] = st_r.cfg[dcp_pkg::SSP_BIT];   // RQ5
        end
        if (I_ERASE) begin
            st_nxt.cfg = dcp_pkg::CFG_DEFAULT;                       // RQ7
            st_nxt.cp  = dcp_pkg::CP_DEFAULT;                        // RQ10
        end else if (I_WR_STB && cfg_hit) begin
            st_nxt.cfg = cfg_wr;                                     // RQ3
        end else if (I_WR_STB && cp_hit) begin
            // Writing a one leaves the bit alone, so protection only grows
            st_nxt.cp = st_r.cp & dcp_pkg::dcp_clean(I_WDATA,
                                         dcp_pkg::CP_IMPL_MASK);     // RQ10
        end
        if (I_RD_STB && cfg_hit) begin
            st_nxt.rdata = dcp_pkg::dcp_clean(st_r.cfg,
                                              dcp_pkg::CFG_IMPL_MASK); // RQ3
        end else if (I_RD_STB && cp_hit) begin
            st_nxt.rdata = dcp_pkg::dcp_clean(st_r.cp,
                                              dcp_pkg::CP_IMPL_MASK);  // RQ3
        end
    end

    // State register; reset stands for the unprogrammed part
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r.cfg     <= dcp_pkg::CFG_DEFAULT;                    // RQ7
            st_r.cp      <= dcp_pkg::CP_DEFAULT;                     // RQ10
            st_r.rdata   <= 8'h00;
            st_r.stk_rst <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from the state flops
    // ------------------------------------------------------------------
    assign O_RDATA                     = st_r.rdata;
    assign O_DEBUG_DATA_PIN_GPIO       = st_r.cfg[dcp_pkg::DBG_SEL_BIT]; // RQ1
    assign O_EXT_INSTR_ENABLE          = st_r.cfg[dcp_pkg::EXT_ISA_BIT]; // RQ2
    assign O_INDEXED_ADDR_ENABLE       = st_r.cfg[dcp_pkg::EXT_ISA_BIT]; // RQ2
    assign O_SINGLE_SUPPLY_PROG_ENABLE = st_r.cfg[dcp_pkg::SSP_BIT];     // RQ4
    assign O_STACK_FAULT_RESET         = st_r.stk_rst;

    // Protection decode; adds one cycle after a change of the protect bits
    dcp_block_protect #(
        .SMALL_MEM (SMALL_MEM)
    ) u_protect (
        .i_clk     (I_SYS_CLK),
        .i_rst_n   (rst_n),
        .i_cp_bits (st_r.cp[3:0]),
        .o_protect (O_BLOCK_PROTECT)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_debug_pin_map: assert property (                              // RQ1
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && cfg_hit && !I_ERASE)
        |=> O_DEBUG_DATA_PIN_GPIO == $past(I_WDATA[7]))
        else $error("debug pin select not taken from write");

    a_ext_instr_map: assert property (                              // RQ2
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && cfg_hit && !I_ERASE)
        |=> O_EXT_INSTR_ENABLE == $past(I_WDATA[6])
            && O_INDEXED_ADDR_ENABLE == O_EXT_INSTR_ENABLE)
        else $error("extension enables not taken from write");

    a_unused_zero: assert property (                                // RQ3
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_RD_STB && cfg_hit) |=> (O_RDATA & 8'h3A) == 8'h00)
        else $error("unused config bits read nonzero");

    a_cp_upper_zero: assert property (                              // RQ3
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_RD_STB && cp_hit) |=> O_RDATA[7:4] == 4'h0
            && O_RDATA[3:0] == $past(st_r.cp[3:0]))
        else $error("protect byte read wrong");

    a_ssp_write: assert property (                                  // RQ4
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && cfg_hit && I_HV_PROG_MODE && !I_ERASE)
        |=> O_SINGLE_SUPPLY_PROG_ENABLE == $past(I_WDATA[2]))
        else $error("single supply bit not written in HV mode");

    a_ssp_guard: assert property (                                  // RQ5
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (!I_HV_PROG_MODE && !I_ERASE)
        |=> $stable(O_SINGLE_SUPPLY_PROG_ENABLE))
        else $error("single supply bit changed outside HV mode");

    a_stack_reset: assert property (                                // RQ6
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        ##1 O_STACK_FAULT_RESET == ($past(st_r.cfg[0])
            && ($past(I_STACK_FULL) || $past(I_STACK_UNDERFLOW))))
        else $error("stack fault reset request wrong");

    a_erase_defaults: assert property (                             // RQ7
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        I_ERASE |=> st_r.cfg == 8'h85 && st_r.cp == 8'h0F)
        else $error("erase did not restore unprogrammed values");

    a_cp_clear_only: assert property (                              // RQ10
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        !I_ERASE |=> (st_r.cp & ~$past(st_r.cp)) == 8'h00)
        else $error("protect bit returned to one without erase");

    a_cp_follow: assert property (                                  // RQ8
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && cp_hit && !I_ERASE && !I_WDATA[0])
        |=> ##1 O_BLOCK_PROTECT[0])
        else $error("block 0 not protected two cycles after clear");

    a_read_window: assert property (
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        !$past(I_RD_STB) |-> O_RDATA == 8'h00)
        else $error("read data outside its cycle");

    // A cleared stack-fault bit keeps faults away from the reset request
    a_stack_quiet: assert property (                                // RQ6
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        !st_r.cfg[dcp_pkg::STK_RST_BIT] |=> !O_STACK_FAULT_RESET)
        else $error("stack fault reset while disabled");

    // Unmapped addresses read back as zero
    a_unmapped_read: assert property (                              // RQ3
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_RD_STB && !cfg_hit && !cp_hit) |=> O_RDATA == 8'h00)
        else $error("unmapped address read nonzero");

    // Writes to unmapped addresses must not disturb either byte
    a_unmapped_write: assert property (
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && !cfg_hit && !cp_hit && !I_ERASE)
        |=> $stable(st_r.cfg) && $stable(st_r.cp))
        else $error("unmapped write changed a byte");

    // Erase brings every config output back to its unprogrammed level
    a_erase_outputs: assert property (                              // RQ7
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        I_ERASE |=> O_DEBUG_DATA_PIN_GPIO && !O_EXT_INSTR_ENABLE
            && !O_INDEXED_ADDR_ENABLE && O_SINGLE_SUPPLY_PROG_ENABLE)
        else $error("erase left a config output programmed");

    // A protect write can only clear bits: new value is old and data
    a_cp_write_and: assert property (                               // RQ10
        @(posedge I_SYS_CLK) disable iff (!rst_n)
        (I_WR_STB && cp_hit && !I_ERASE)
        |=> st_r.cp == ($past(st_r.cp) & $past(I_WDATA) & 8'h0F))
        else $error("protect write did not clear only");

endmodule

// >>> inc/dcp_pkg.sv
package dcp_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register addresses
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NUM_BLOCKS = 4;

    localparam logic [7:0] CFG_ADDR = 8'h00;
    localparam logic [7:0] CP_ADDR  = 8'h01;

    // ------------------------------------------------------------------
    // Field positions of the debug and instruction byte
    // ------------------------------------------------------------------
    localparam int unsigned DBG_SEL_BIT = 7;
    localparam int unsigned EXT_ISA_BIT = 6;
    localparam int unsigned SSP_BIT     = 2;
    localparam int unsigned STK_RST_BIT = 0;

    // ------------------------------------------------------------------
    // Implemented masks and unprogrammed values
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_IMPL_MASK = 8'hC5;
    localparam logic [7:0] CFG_DEFAULT   = 8'h85;
    localparam logic [7:0] CP_IMPL_MASK  = 8'h0F;
    localparam logic [7:0] CP_DEFAULT    = 8'h0F;
    localparam logic [3:0] SMALL_INERT   = 4'hC;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] cp;
        logic [7:0] rdata;
        logic       stk_rst;
    } dcp_state_s;

    typedef struct packed {
        logic [3:0] prot;
    } dcp_prot_s;

    // Unimplemented positions are forced to zero
    function automatic logic [7:0] dcp_clean(input logic [7:0] v,
                                             input logic [7:0] m);
        return v & m;
    endfunction

endpackage

// >>> src/dcp_block_protect.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Per-block code protection from the clearable protect bits
// ----------------------------------------------------------------------
module dcp_block_protect #(
    parameter bit SMALL_MEM = 1'b0
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_cp_bits,
    output logic      [3:0] o_protect
);

    dcp_pkg::dcp_prot_s st_r;
    dcp_pkg::dcp_prot_s st_nxt;

    // A zero bit protects its block; upper blocks are inert on small parts
    always_comb begin
        st_nxt      = st_r;
        st_nxt.prot = ~i_cp_bits;                                   // RQ8
        if (SMALL_MEM) begin
            st_nxt.prot = st_nxt.prot & ~dcp_pkg::SMALL_INERT;      // RQ9
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_protect = st_r.prot;

    // Blocks 1 and 0 follow the bits one cycle later with the right polarity
    a_cp_polarity: assert property (                                // RQ8
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_protect[1:0] == ~$past(i_cp_bits[1:0]))
        else $error("block protect polarity wrong");

    // Small parts never protect blocks 3 and 2
    a_small_inert: assert property (                                // RQ9
        @(posedge i_clk) disable iff (!i_rst_n)
        SMALL_MEM |-> o_protect[3:2] == 2'b00)
        else $error("inert block shows protection");

endmodule

// >>> dv/dcp_prog_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Programmer model on the register port
// ------------------------------------------------------------------
module dcp_prog_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr_stb,
    output logic            o_rd_stb,
    output logic            o_hv_prog_mode
);
    // Idle bus at time zero
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_hv_prog_mode = 1'b0;
    end

    // One-cycle write; high voltage only for the writes that ask for it
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             input logic hv);
        @(posedge i_clk);
        o_wr_stb <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        o_hv_prog_mode <= hv;
        @(posedge i_clk);
        o_wr_stb <= 1'b0;
        o_addr <= ~a; // Released bus never shows the stale value
        o_wdata <= ~d;
        o_hv_prog_mode <= 1'b0;
    endtask

    // One-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd_stb <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// >>> dv/test_dcp_config.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Self-checking bench for the configuration bytes
// ------------------------------------------------------------------
module test_dcp_config;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       erase = 1'b0;
    logic       full = 1'b0;
    logic       unf = 1'b0;
    logic [7:0] addr, wdata, rdata, v;
    logic       wr, rd, hv, gpio, ext, idx, ssp, sfr;
    logic [3:0] bp, bp_s;
    int         n_fail = 0;
    int         n_compared = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    dcp_prog_model prog (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr_stb(wr), .o_rd_stb(rd),
        .o_hv_prog_mode(hv));

    dcp_config uut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR_STB(wr), .I_RD_STB(rd), .O_RDATA(rdata),
        .I_HV_PROG_MODE(hv), .I_ERASE(erase), .I_STACK_FULL(full),
        .I_STACK_UNDERFLOW(unf), .O_DEBUG_DATA_PIN_GPIO(gpio),
        .O_EXT_INSTR_ENABLE(ext), .O_INDEXED_ADDR_ENABLE(idx),
        .O_SINGLE_SUPPLY_PROG_ENABLE(ssp), .O_STACK_FAULT_RESET(sfr),
        .O_BLOCK_PROTECT(bp));

    // Small-memory variant shares the bus; only its protect output is read
    dcp_config #(.SMALL_MEM(1'b1)) uut_small (
        .I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR_STB(wr), .I_RD_STB(rd), .O_RDATA(),
        .I_HV_PROG_MODE(hv), .I_ERASE(erase), .I_STACK_FULL(full),
        .I_STACK_UNDERFLOW(unf), .O_DEBUG_DATA_PIN_GPIO(),
        .O_EXT_INSTR_ENABLE(), .O_INDEXED_ADDR_ENABLE(),
        .O_SINGLE_SUPPLY_PROG_ENABLE(), .O_STACK_FAULT_RESET(),
        .O_BLOCK_PROTECT(bp_s));

    // Case inequality so an unknown never passes
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Packs gpio, ext, indexed, single-supply, stack reset
    task automatic chk_out(logic [4:0] exp);
        chk("outputs", {3'h0, gpio, ext, idx, ssp, sfr}, {3'h0, exp});
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        prog.read_reg(a, v);
        chk("read data", v, exp);
    endtask

    // One cycle of stack fault, request checked for exactly one cycle
    task automatic fault(logic f, logic u, logic exp);
        @(posedge clk);
        full <= f;
        unf <= u;
        @(posedge clk);
        full <= 1'b0;
        unf <= 1'b0;
        #1;
        chk("stack reset", {7'h0, sfr}, {7'h0, exp});
        @(posedge clk);
        #1;
        chk("stack reset end", {7'h0, sfr}, 8'h00);
    endtask

    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'h00, 8'h85);
        rd_chk(8'h01, 8'h0F);
        rd_chk(8'h02, 8'h00);
        chk_out(5'b10010);
        chk("protect", {4'h0, bp}, 8'h00);
        chk("protect small", {4'h0, bp_s}, 8'h00);
        $display("test defaults done");
        prog.write_reg(8'h00, 8'h00, 1'b1);
        #1;
        chk_out(5'b00000);
        // Without high voltage the single-supply bit must hold at zero
        prog.write_reg(8'h00, 8'hFF, 1'b0);
        #1;
        chk_out(5'b11100);
        // An unmapped write must leave the config byte alone
        prog.write_reg(8'h02, 8'h00, 1'b1);
        rd_chk(8'h00, 8'hC1);
        fault(1'b1, 1'b0, 1'b1);
        fault(1'b0, 1'b1, 1'b1);
        prog.write_reg(8'h00, 8'hC4, 1'b1);
        #1;
        chk_out(5'b11110);
        fault(1'b1, 1'b1, 1'b0);
        $display("test config byte done");
        prog.write_reg(8'h01, 8'h0E, 1'b0);
        rd_chk(8'h01, 8'h0E);
        chk("protect", {4'h0, bp}, 8'h01);
        // Setting bits back to one is refused by a write
        prog.write_reg(8'h01, 8'hFF, 1'b0);
        rd_chk(8'h01, 8'h0E);
        prog.write_reg(8'h01, 8'hF5, 1'b0);
        rd_chk(8'h01, 8'h04);
        chk("protect", {4'h0, bp}, 8'h0B);
        chk("protect small", {4'h0, bp_s}, 8'h03);
        $display("test protect byte done");
        @(posedge clk);
        erase <= 1'b1;
        @(posedge clk);
        erase <= 1'b0;
        rd_chk(8'h00, 8'h85);
        rd_chk(8'h01, 8'h0F);
        chk("protect", {4'h0, bp}, 8'h00);
        $display("test erase done");
        summarize();
    end
endmodule
